/* File: core/fpw_top.sv */
// fan pwm generator: duty code, frequency select, spin-up and read-back
// assumes register requests and mode inputs synchronous to clk_sys_i at 125 MHz
`timescale 1ns/1ns
`default_nettype none
`include "fpw_map.svh"

module fpw_top #(
	parameter int unsigned CYC_PER_MS = 125000 // system cycles per millisecond
) (
	input  wire logic              clk_sys_i,          // 125 MHz system clock
	input  wire logic              arst_n_i,           // asynchronous reset, active low
	input  wire fpw_pkg::fpw_req_s reg_req_i,          // register address, write strobe, data
	input  wire logic              reg_rd_i,           // read strobe
	output logic [7:0]             reg_rdata_o,        // read data, valid the cycle after reg_rd_i
	input  wire fpw_pkg::fpw_mode_e ctrl_mode_i,       // active control mode
	input  wire logic              speed_sense_mode_select_i, // 0 enables minimum-duty forcing
	input  wire logic [7:0]        computed_duty_i,    // duty from rpm or temperature loop
	input  wire logic              range_strap_i,      // 1: low frequency range, 0: high range
	input  wire logic              spinup_req_i,       // pulse: fan start requested
	output logic                   spinup_active_o,    // spin-up phase in progress
	output logic                   fan_pwm_o           // fan drive output
);

	logic [7:0]  fan_char_reg;     // fan characteristics register
	logic [7:0]  duty_code_reg;    // written duty code, shadow in other modes
	logic        strap_reg;        // range strap caught after reset release
	logic        strap_done_reg;   // strap already caught
	logic [10:0] tb_acc_reg;       // fractional timebase accumulator
	logic        tb_tick;          // one 3.2 MHz timebase tick
	logic [18:0] pos_reg;          // position inside the pwm period
	logic [18:0] period;           // period in timebase ticks
	logic [7:0]  duty_sel;         // duty before forcing, used for read-back
	logic [7:0]  duty_out;         // duty driving the output
	logic [16:0] ms_cnt_reg;       // system cycles inside one millisecond
	logic [12:0] spin_ms_reg;      // milliseconds left in spin-up
	logic [12:0] spin_len;         // selected spin-up length in ms
	fpw_pkg::fpw_spin_e spin_state_reg; // spin-up sequencer state
	logic [2:0]  freq_select;      // frequency select field
	logic [2:0]  spinup_time_select; // spin-up time field
	logic        spinup_disable;   // spin-up disable bit
	logic [27:0] lhs;              // pos scaled by 255
	logic [26:0] rhs;              // period scaled by duty

	assign freq_select        = fan_char_reg[`FPW_FREQ_MSB:`FPW_FREQ_LSB];
	assign spinup_time_select = fan_char_reg[`FPW_STIME_MSB:`FPW_STIME_LSB];
	assign spinup_disable     = fan_char_reg[`FPW_BIT_SPINUP_DIS];

	// register writes: fan characteristics with reserved bit masked
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fan_char_reg <= `FPW_RST_FAN_CHAR;
		end else if (reg_req_i.wr && reg_req_i.addr == `FPW_OFS_FAN_CHAR) begin
			fan_char_reg <= reg_req_i.wdata & `FPW_FAN_CHAR_WR_MASK;
		end
	end

	// duty code register: always stores, only steers output in software duty mode
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			duty_code_reg <= `FPW_RST_DUTY_CODE;
		end else if (reg_req_i.wr && reg_req_i.addr == `FPW_OFS_DUTY_CODE) begin
			duty_code_reg <= reg_req_i.wdata;
		end
	end

	// strap is sampled once, on the first edge after reset release
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			strap_reg      <= 1'b1;
			strap_done_reg <= 1'b0;
		end else if (!strap_done_reg) begin
			strap_reg      <= range_strap_i;
			strap_done_reg <= 1'b1;
		end
	end

	// duty source and minimum forcing
	always_comb begin
		// software duty mode uses the register, shadowed value applies at once
		duty_sel = (ctrl_mode_i == fpw_pkg::FPW_MODE_SW_DUTY) ? duty_code_reg
			: computed_duty_i;
		duty_out = duty_sel;
		if (!speed_sense_mode_select_i) begin
			if (ctrl_mode_i == fpw_pkg::FPW_MODE_SW_RPM) begin
				// rpm mode holds the fan at a minimum drive
				if (duty_sel < `FPW_DUTY_MIN_RPM) begin
					duty_out = `FPW_DUTY_MIN_RPM;
				end
			end else if (duty_sel < `FPW_DUTY_MIN_ON) begin
				// too low to turn the fan reliably, switch it off
				duty_out = `FPW_DUTY_ZERO;
			end
		end
		if (spin_state_reg == fpw_pkg::FPW_SPIN_RUN) begin
			duty_out = `FPW_DUTY_FULL;
		end
	end

	// read data: unforced duty, reserved bit already zero in storage
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			case (reg_req_i.addr)
				`FPW_OFS_FAN_CHAR:  reg_rdata_o <= fan_char_reg;
				`FPW_OFS_DUTY_CODE: reg_rdata_o <= duty_sel;
				default:            reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// 3.2 MHz timebase from 125 MHz by a 32/1250 fractional accumulator
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tb_acc_reg <= 11'h000;
		end else if (tb_tick) begin
			tb_acc_reg <= 11'(32'(tb_acc_reg) + `FPW_TB_NUM - `FPW_TB_DEN);
		end else begin
			tb_acc_reg <= 11'(32'(tb_acc_reg) + `FPW_TB_NUM);
		end
	end
	assign tb_tick = (32'(tb_acc_reg) + `FPW_TB_NUM) >= `FPW_TB_DEN;

	// period per frequency code and range, in 3.2 MHz ticks
	always_comb begin
		if (strap_reg) begin
			case (freq_select)
				3'h0:    period = `FPW_PER_LO_0;
				3'h1:    period = `FPW_PER_LO_1;
				3'h2:    period = `FPW_PER_LO_2;
				3'h3:    period = `FPW_PER_LO_3;
				3'h4:    period = `FPW_PER_LO_4;
				3'h5:    period = `FPW_PER_LO_5;
				3'h6:    period = `FPW_PER_LO_6;
				default: period = `FPW_PER_LO_7;
			endcase
		end else begin
			case (freq_select)
				3'h0:    period = `FPW_PER_HI_0;
				3'h1:    period = `FPW_PER_HI_1;
				3'h2:    period = `FPW_PER_HI_2;
				3'h3:    period = `FPW_PER_HI_3;
				3'h4:    period = `FPW_PER_HI_4;
				default: period = `FPW_PER_HI_5;
			endcase
		end
	end

	// period counter, restarts when the period shrinks below the position
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pos_reg <= 19'h00000;
		end else if (tb_tick) begin
			pos_reg <= (pos_reg >= period - 19'h00001) ? 19'h00000
				: pos_reg + 19'h00001;
		end
	end

	// high while pos/period < duty/255: linear, 0x00 never, 0xff always
	assign lhs = 28'({pos_reg, 8'h00}) - 28'(pos_reg);
	// both factors widened first so the product cannot wrap at 19 bits
	assign rhs = 27'(period) * 27'(duty_out);
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fan_pwm_o <= 1'b0;
		end else begin
			fan_pwm_o <= lhs < 28'(rhs);
		end
	end

	// spin-up length in milliseconds
	always_comb begin
		case (spinup_time_select)
			3'h0:    spin_len = `FPW_SPIN_MS_0;
			3'h1:    spin_len = `FPW_SPIN_MS_1;
			3'h2:    spin_len = `FPW_SPIN_MS_2;
			3'h3:    spin_len = `FPW_SPIN_MS_3;
			3'h4:    spin_len = `FPW_SPIN_MS_4;
			3'h5:    spin_len = `FPW_SPIN_MS_5;
			3'h6:    spin_len = `FPW_SPIN_MS_6;
			default: spin_len = `FPW_SPIN_MS_7;
		endcase
	end

	// spin-up sequencer, timed in whole milliseconds
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			spin_state_reg <= fpw_pkg::FPW_SPIN_IDLE;
			spin_ms_reg    <= 13'h0000;
			ms_cnt_reg     <= 17'h00000;
		end else begin
			case (spin_state_reg)
				fpw_pkg::FPW_SPIN_IDLE: begin
					// a disabled spin-up ignores the time field entirely
					if (spinup_req_i && !spinup_disable) begin
						spin_state_reg <= fpw_pkg::FPW_SPIN_RUN;
						spin_ms_reg    <= spin_len;
						ms_cnt_reg     <= 17'h00000;
					end
				end
				fpw_pkg::FPW_SPIN_RUN: begin
					if (32'(ms_cnt_reg) >= CYC_PER_MS - 1) begin
						ms_cnt_reg  <= 17'h00000;
						spin_ms_reg <= spin_ms_reg - 13'h0001;
						if (spin_ms_reg == 13'h0001) begin
							spin_state_reg <= fpw_pkg::FPW_SPIN_IDLE;
						end
					end else begin
						ms_cnt_reg <= ms_cnt_reg + 17'h00001;
					end
				end
				default: spin_state_reg <= fpw_pkg::FPW_SPIN_IDLE;
			endcase
		end
	end
	assign spinup_active_o = spin_state_reg == fpw_pkg::FPW_SPIN_RUN;

endmodule
`default_nettype wire

/* File: core/fpw_map.svh */
// register offsets, reset values, field positions and timing counts of the fan pwm block
// assumes a byte-wide register port with 8-bit addresses
`ifndef FPW_MAP_SVH
`define FPW_MAP_SVH

`define FPW_OFS_FAN_CHAR      8'h20
`define FPW_OFS_DUTY_CODE     8'h22
`define FPW_RST_FAN_CHAR      8'h1d
`define FPW_RST_DUTY_CODE     8'h55
`define FPW_FAN_CHAR_WR_MASK  8'hbf
`define FPW_BIT_SPINUP_DIS    7
`define FPW_FREQ_MSB          5
`define FPW_FREQ_LSB          3
`define FPW_STIME_MSB         2
`define FPW_STIME_LSB         0
`define FPW_DUTY_FULL         8'hff
`define FPW_DUTY_ZERO         8'h00
`define FPW_DUTY_MIN_RPM      8'h4d
`define FPW_DUTY_MIN_ON       8'h12
`define FPW_TB_NUM            32'h20
`define FPW_TB_DEN            32'h4e2
// pwm periods in 3.2 MHz ticks, strap high (Hz range), codes 0 to 7
`define FPW_PER_LO_0          19'h4e200
`define FPW_PER_LO_1          19'h34155
`define FPW_PER_LO_2          19'h21f7a
`define FPW_PER_LO_3          19'h1a0ab
`define FPW_PER_LO_4          19'h148f3
`define FPW_PER_LO_5          19'h109f5
`define FPW_PER_LO_6          19'h0c99d
`define FPW_PER_LO_7          19'h084fb
// pwm periods in 3.2 MHz ticks, strap low (kHz range), codes 0 to 5, 6 and 7 as 5
`define FPW_PER_HI_0          19'h00c80
`define FPW_PER_HI_1          19'h00140
`define FPW_PER_HI_2          19'h000a0
`define FPW_PER_HI_3          19'h00080
`define FPW_PER_HI_4          19'h0006b
`define FPW_PER_HI_5          19'h00050
// spin-up lengths in milliseconds, codes 0 to 7
`define FPW_SPIN_MS_0         13'h00c8
`define FPW_SPIN_MS_1         13'h0190
`define FPW_SPIN_MS_2         13'h0258
`define FPW_SPIN_MS_3         13'h0320
`define FPW_SPIN_MS_4         13'h03e8
`define FPW_SPIN_MS_5         13'h07d0
`define FPW_SPIN_MS_6         13'h0fa0
`define FPW_SPIN_MS_7         13'h1f40
`define FPW_SYS_MHZ           125
`define FPW_TB_KHZ            3200

`endif

/* File: core/fpw_pkg.sv */
// types shared by the fan pwm block
// no imports; constants live in fpw_map.svh
package fpw_pkg;

	// control modes that decide where the applied duty comes from
	typedef enum logic [1:0] {
		FPW_MODE_SW_DUTY,
		FPW_MODE_SW_RPM,
		FPW_MODE_AUTO_TEMP
	} fpw_mode_e;

	// register access request
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} fpw_req_s;

	// spin-up sequencer states
	typedef enum logic {
		FPW_SPIN_IDLE,
		FPW_SPIN_RUN
	} fpw_spin_e;

endpackage

/* File: tb/fpw_fan_model.sv */
// cooling fan model: times the drive pulses it receives
// assumes the drive is sampled on the system clock
`timescale 1ns/1ns
`default_nettype none
module fpw_fan_model (
	input  wire logic clk_i,   // sampling clock
	input  wire logic pwm_i,   // drive from the block
	output var  int   per_o,   // last full period in clocks
	output var  int   hi_o,    // high clocks of that period
	output var  int   edges_o  // rising edges seen
);
	int   cnt;  // clocks since last rise
	int   hcnt; // high clocks since last rise
	logic prev; // drive one clock ago
	initial begin
		{per_o, hi_o, edges_o, cnt, hcnt} = '0;
		prev = 1'b0;
	end
	// a rise closes one period and opens the next
	always @(posedge clk_i) begin
		prev <= pwm_i;
		if (pwm_i && !prev) begin
			per_o <= cnt;
			hi_o <= hcnt;
			edges_o <= edges_o + 1;
			cnt <= 1;
			hcnt <= 1;
		end else begin
			cnt <= cnt + 1;
			hcnt <= hcnt + int'(pwm_i);
		end
	end
endmodule
`default_nettype wire

/* File: tb/fpw_top_props.sv */
// checker for the fan pwm block
// assumes only the ports of fpw_top
`timescale 1ns/1ns
`default_nettype none
`include "fpw_map.svh"
module fpw_top_props #(
	parameter int unsigned CYC_PER_MS = 125000 // cycles per millisecond
) (
	input wire logic               clk_sys_i,
	input wire logic               arst_n_i,
	input wire fpw_pkg::fpw_req_s  reg_req_i,
	input wire logic               reg_rd_i,
	input wire logic [7:0]         reg_rdata_o,
	input wire fpw_pkg::fpw_mode_e ctrl_mode_i,
	input wire logic               speed_sense_mode_select_i,
	input wire logic [7:0]         computed_duty_i,
	input wire logic               range_strap_i,
	input wire logic               spinup_req_i,
	input wire logic               spinup_active_o,
	input wire logic               fan_pwm_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);
	logic [31:0] spin_cnt; // length of running spin-up
	logic        auto_idle; // automatic mode, no spin-up
	assign auto_idle = ctrl_mode_i == fpw_pkg::FPW_MODE_AUTO_TEMP && !spinup_active_o;
	// count spin-up cycles
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i)
			spin_cnt <= '0;
		else
			spin_cnt <= spinup_active_o ? spin_cnt + 32'h1 : '0;
	end
	a_spin_full: assert property (spinup_active_o [*2] |-> fan_pwm_o) else $error("low in spin");
	a_spin_cause: assert property ($rose(spinup_active_o) |-> $past(spinup_req_i)) else $error("spin");
	a_spin_bound: assert property (spin_cnt <= 8000 * CYC_PER_MS) else $error("spin too long");
	a_rd_hold: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o)) else $error("rdata moved");
	a_rd_computed: assert property (reg_rd_i && reg_req_i.addr == `FPW_OFS_DUTY_CODE &&
		ctrl_mode_i != fpw_pkg::FPW_MODE_SW_DUTY |=> reg_rdata_o == $past(computed_duty_i))
		else $error("duty readback");
	a_char_rsvd: assert property (reg_rd_i && reg_req_i.addr == `FPW_OFS_FAN_CHAR
		|=> !reg_rdata_o[6]) else $error("reserved bit set");
	a_duty_zero: assert property ((auto_idle && computed_duty_i == 8'h00) [*2] |-> !fan_pwm_o)
		else $error("zero duty drives");
	a_duty_full: assert property ((auto_idle && computed_duty_i == 8'hff) [*2] |-> fan_pwm_o)
		else $error("full duty drops");
	a_low_cut: assert property ((auto_idle && !speed_sense_mode_select_i &&
		computed_duty_i < `FPW_DUTY_MIN_ON) [*2] |-> !fan_pwm_o) else $error("low duty drives");
	c_spin: cover property ($fell(spinup_active_o));
	c_rd: cover property (reg_rd_i && reg_req_i.addr == `FPW_OFS_DUTY_CODE);
	c_rpm: cover property (ctrl_mode_i == fpw_pkg::FPW_MODE_SW_RPM && !speed_sense_mode_select_i);
endmodule
bind fpw_top fpw_top_props #(.CYC_PER_MS(CYC_PER_MS)) fpw_top_props_inst (.clk_sys_i(clk_sys_i),
	.arst_n_i(arst_n_i), .reg_req_i(reg_req_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.ctrl_mode_i(ctrl_mode_i), .speed_sense_mode_select_i(speed_sense_mode_select_i),
	.computed_duty_i(computed_duty_i), .range_strap_i(range_strap_i),
	.spinup_req_i(spinup_req_i), .spinup_active_o(spinup_active_o), .fan_pwm_o(fan_pwm_o));
`default_nettype wire

/* File: tb/tb_top.sv */
// testbench of the fan pwm block, one task per scenario
// assumes strap low (kHz range) until the last scenario, and a shortened millisecond
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic               clk = 0, arst_n = 0, rd = 0, ss = 1, strap = 0, sreq = 0; // inputs
	logic [7:0]         comp = 8'h00, rdata; // computed duty, read data
	logic               spin, pwm; // block outputs
	fpw_pkg::fpw_req_s  req = '0; // register request
	fpw_pkg::fpw_mode_e mode = fpw_pkg::FPW_MODE_SW_DUTY; // control mode
	int                 per, hi, edges, n_errors = 0, checks = 0; // fan timing, counters
	int                 ptab[8] = '{3200, 320, 160, 128, 107, 80, 80, 80}; // periods in ticks
	initial forever #4 clk = ~clk;
	fpw_top #(.CYC_PER_MS(10)) fpw_top_inst (.clk_sys_i(clk), .arst_n_i(arst_n), .reg_req_i(req),
		.reg_rd_i(rd), .reg_rdata_o(rdata), .ctrl_mode_i(mode), .speed_sense_mode_select_i(ss),
		.computed_duty_i(comp), .range_strap_i(strap), .spinup_req_i(sreq),
		.spinup_active_o(spin), .fan_pwm_o(pwm));
	fpw_fan_model fpw_fan_model_inst (.clk_i(clk), .pwm_i(pwm), .per_o(per), .hi_o(hi),
		.edges_o(edges));
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task end_of_test;
		if (n_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// one-cycle register write
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		req = '{1'b1, a, d};
		@(negedge clk);
		req.wr = 1'b0;
	endtask
	// one-cycle read, data judged a cycle later
	task rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		req.addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		chk(rdata, e);
	endtask
	// let a new setting reach the fan first, so a mid-period rise is not taken as a start,
	// then wait two fan periods and judge period and high time within two clocks
	task meas(input int p, input int d);
		int e0;
		repeat (2) @(negedge clk);
		e0 = edges;
		for (int i = 0; i < 40000 && edges < e0 + 2; i++) @(negedge clk);
		chk(edges >= e0 + 2, 1'b1);
		chk((per - p * 1250 / 32) ** 2 <= 4, 1'b1);
		chk((hi - (p * d + 254) / 255 * 1250 / 32) ** 2 <= 4, 1'b1);
	endtask
	task t_regs;
		rd_chk(8'h20, 8'h1d);
		rd_chk(8'h22, 8'h55);
		rd_chk(8'h21, 8'h00);
		wr(8'h20, 8'hff);
		rd_chk(8'h20, 8'hbf);
	endtask
	task t_spin(input logic [7:0] c, input int n_exp);
		int n;
		n = 0;
		wr(8'h20, c);
		sreq = 1'b1;
		@(negedge clk);
		sreq = 1'b0;
		while (spin === 1'b1 && n < 30000) begin
			n++;
			@(negedge clk);
		end
		chk(n, n_exp);
	endtask
	task t_modes;
		mode = fpw_pkg::FPW_MODE_AUTO_TEMP;
		comp = 8'h30;
		wr(8'h22, 8'hc0);
		rd_chk(8'h22, 8'h30);
		for (int i = 0; i < 3; i++) begin
			comp = i == 0 ? 8'hff : 8'h11 * (i - 1);
			ss = i == 1;
			repeat (4) @(negedge clk);
		end
		rd_chk(8'h22, 8'h11);
		ss = 1'b1;
		mode = fpw_pkg::FPW_MODE_SW_DUTY;
		rd_chk(8'h22, 8'hc0);
		meas(128, 8'hc0);
		mode = fpw_pkg::FPW_MODE_SW_RPM;
		ss = 1'b0;
		comp = 8'h10;
		rd_chk(8'h22, 8'h10);
		meas(128, 8'h4d);
	endtask
	task t_freq;
		mode = fpw_pkg::FPW_MODE_SW_DUTY;
		ss = 1'b1;
		wr(8'h22, 8'h80);
		for (int c = 2; c < 8; c++) begin
			wr(8'h20, {2'b10, 3'(c), 3'b000});
			meas(ptab[c], 8'h80);
		end
	endtask
	// mid-run reset with the strap high: reset values return, low range gives a long high phase
	task t_strap;
		int n;
		n = 0;
		arst_n = 1'b0;
		strap = 1'b1;
		repeat (2) @(negedge clk);
		arst_n = 1'b1;
		rd_chk(8'h22, 8'h55);
		rd_chk(8'h20, 8'h1d);
		repeat (4000) begin
			@(negedge clk);
			n += int'(pwm === 1'b1);
		end
		chk(n, 4000);
	endtask
	initial begin
		repeat (6) @(negedge clk);
		arst_n = 1'b1;
		t_regs;
		t_spin(8'h18, 2000);
		t_spin(8'h98, 0);
		t_modes;
		t_freq;
		t_strap;
		end_of_test;
	end
	// cut a hang short
	initial begin
		#1600000;
		n_errors++;
		end_of_test;
	end
endmodule
`default_nettype wire
